// ===== src/prs_cfg.svh
// constants of the pressure mode control and readout block
// assumes a 125 MHz core clock; all times are converted from it
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// core clock rate
`define PRS_CLK_HZ 125000000
`define PRS_CYC_PER_MS (`PRS_CLK_HZ / 1000)

// operation command codes
`define PRS_OP_CANCEL 8'h00
`define PRS_OP_HISPEED 8'h09
`define PRS_OP_HIRES 8'h0a
`define PRS_OP_ULP 8'h0b
`define PRS_OP_TRIG 8'h0c

// measurement and computation times in ms, typical figures
`define PRS_HIRES_MS 500
`define PRS_HISPEED_MS 140
`define PRS_ULP_MS 1000
`define PRS_TRIG_MS 500
// time to wind down a cancelled operation, in ms
`define PRS_STOP_MS 1

// derived cycle counts
`define PRS_HIRES_CYC (`PRS_HIRES_MS * `PRS_CYC_PER_MS)
`define PRS_HISPEED_CYC (`PRS_HISPEED_MS * `PRS_CYC_PER_MS)
`define PRS_ULP_CYC (`PRS_ULP_MS * `PRS_CYC_PER_MS)
`define PRS_TRIG_CYC (`PRS_TRIG_MS * `PRS_CYC_PER_MS)
`define PRS_STOP_CYC (`PRS_STOP_MS * `PRS_CYC_PER_MS)

// result field layout
`define PRS_P_W 19
`define PRS_T_W 14
`define PRS_T_SIGN 13
`define PRS_PH_W 3
`define PRS_PL_W 16
`define PRS_TIMER_W 32

`endif

// ===== src/prs_pkg.sv
// types of the pressure mode control and readout block
// assumes prs_cfg.svh is on the include path
`include "prs_cfg.svh"

package prs_pkg;

  // operating state, one-hot
  typedef enum logic [4:0] {
    PRS_ST_STANDBY = 5'h01,
    PRS_ST_CONT = 5'h02,
    PRS_ST_TRIG_WAIT = 5'h04,
    PRS_ST_TRIG_MEAS = 5'h08,
    PRS_ST_STOP = 5'h10
  } prs_state_t;

  // status bits seen by the host
  typedef struct packed {
    logic overrun_error_flag;
    logic operation_busy_flag;
    logic result_ready;
  } prs_status_t;

  // one fresh result from the converter
  typedef struct packed {
    logic [`PRS_P_W-1:0] pressure;
    logic [`PRS_T_W-1:0] temperature;
  } prs_sample_t;

endpackage

// ===== src/prs_readout.sv
// measurement mode control and result readout of a pressure sensor
// assumes a decoded register port from the serial interface, a converter
// on core_clk supplying samples, and an asynchronous trigger pin
`timescale 1ns/10ps

module prs_readout
  import prs_pkg::*;
#(
  parameter logic [`PRS_TIMER_W-1:0] HIRES_CYC = `PRS_HIRES_CYC,
  parameter logic [`PRS_TIMER_W-1:0] HISPEED_CYC = `PRS_HISPEED_CYC,
  parameter logic [`PRS_TIMER_W-1:0] ULP_CYC = `PRS_ULP_CYC,
  parameter logic [`PRS_TIMER_W-1:0] TRIG_CYC = `PRS_TRIG_CYC,
  parameter logic [`PRS_TIMER_W-1:0] STOP_CYC = `PRS_STOP_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic trig_pin,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_data,
  input wire logic rd_pressure_low,
  input wire prs_sample_t conv_sample,
  output logic result_ready_line,
  output prs_status_t status,
  output logic [15:0] temperature_result,
  output logic [7:0] pressure_result_high,
  output logic [15:0] pressure_result_low
);

  // trigger synchroniser and edge memory
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  logic trig_rise;

  // control state
  prs_state_t state;
  prs_state_t next_state;
  logic [`PRS_TIMER_W-1:0] timer;
  logic [`PRS_TIMER_W-1:0] next_timer;
  logic [`PRS_TIMER_W-1:0] period;
  logic [`PRS_TIMER_W-1:0] next_period;

  // result state
  logic ready;
  logic next_ready;
  logic overrun;
  logic next_overrun;
  // busy is held only in the status word, one flop, no private copy
  logic next_busy;
  logic [15:0] next_temp;
  logic [7:0] next_ph;
  logic [15:0] next_pl;
  logic done;

  // trigger pin passes two flops before the edge detector reads it
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= trig_pin;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  assign trig_rise = trig_s2 & ~trig_s3;

  // a measurement finishes when the running timer reaches one
  assign done = (state == PRS_ST_CONT || state == PRS_ST_TRIG_MEAS)
                && timer == `PRS_TIMER_W'(1);

  // mode sequencer next values
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_period = period;
    if (timer != '0) begin
      next_timer = timer - `PRS_TIMER_W'(1);
    end
    unique case (state)
      PRS_ST_STANDBY: begin
        if (cmd_wr && cmd_data == `PRS_OP_HIRES) begin
          next_state = PRS_ST_CONT;
          next_period = HIRES_CYC;
          next_timer = HIRES_CYC;
        end else if (cmd_wr && cmd_data == `PRS_OP_HISPEED) begin
          next_state = PRS_ST_CONT;
          next_period = HISPEED_CYC;
          next_timer = HISPEED_CYC;
        end else if (cmd_wr && cmd_data == `PRS_OP_ULP) begin
          next_state = PRS_ST_CONT;
          next_period = ULP_CYC;
          next_timer = ULP_CYC;
        end else if ((cmd_wr && cmd_data == `PRS_OP_TRIG) || trig_rise) begin
          next_state = PRS_ST_TRIG_MEAS;
          next_timer = TRIG_CYC;
        end
      end
      PRS_ST_CONT: begin
        if (done) begin
          next_timer = period; // restart the next cycle at once
        end
      end
      PRS_ST_TRIG_WAIT: begin
        // stays in trigger wait until the trigger or a cancel
        if ((cmd_wr && cmd_data == `PRS_OP_TRIG) || trig_rise) begin
          next_state = PRS_ST_TRIG_MEAS;
          next_timer = TRIG_CYC;
        end
      end
      PRS_ST_TRIG_MEAS: begin
        if (done) begin
          next_state = PRS_ST_TRIG_WAIT;
        end
      end
      PRS_ST_STOP: begin
        if (timer == `PRS_TIMER_W'(1)) begin
          next_state = PRS_ST_STANDBY;
        end
      end
    endcase
    // cancel wins over everything except an idle standby
    if (cmd_wr && cmd_data == `PRS_OP_CANCEL
        && state != PRS_ST_STANDBY) begin
      next_state = PRS_ST_STOP;
      next_timer = STOP_CYC;
    end
  end

  // busy while measuring, running continuously or winding down
  always_comb begin
    next_busy = (next_state == PRS_ST_CONT)
                || (next_state == PRS_ST_TRIG_MEAS)
                || (next_state == PRS_ST_STOP);
  end

  // result registers, ready and overrun next values
  always_comb begin
    next_temp = temperature_result;
    next_ph = pressure_result_high;
    next_pl = pressure_result_low;
    next_ready = ready;
    next_overrun = overrun;
    if (rd_pressure_low) begin
      next_ready = 1'b0;
      next_overrun = 1'b0;
    end
    if (done) begin
      // 14-bit field kept as is, the unused top two bits read zero
      next_temp = {2'b00, conv_sample.temperature};
      next_ph = {5'h00,
        conv_sample.pressure[`PRS_P_W-1:`PRS_PL_W]};
      next_pl = conv_sample.pressure[`PRS_PL_W-1:0];
      next_ready = 1'b1; // set wins over a same-cycle read
      if (ready && !rd_pressure_low) begin
        next_overrun = 1'b1;
      end
    end
  end

  // register control and result state; the status word and ready pin load below
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= PRS_ST_STANDBY;
      timer <= '0;
      period <= '0;
      ready <= 1'b0;
      overrun <= 1'b0;
      temperature_result <= 16'h0000;
      pressure_result_high <= 8'h00;
      pressure_result_low <= 16'h0000;
    end else begin
      state <= next_state;
      timer <= next_timer;
      period <= next_period;
      ready <= next_ready;
      overrun <= next_overrun;
      temperature_result <= next_temp;
      pressure_result_high <= next_ph;
      pressure_result_low <= next_pl;
    end
  end

  // pin and status bit are separate flops loaded from the same next value
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      result_ready_line <= 1'b0;
      status <= '0;
    end else begin
      result_ready_line <= next_ready;
      status.result_ready <= next_ready;
      status.overrun_error_flag <= next_overrun;
      status.operation_busy_flag <= next_busy;
    end
  end

endmodule // prs_readout

// ===== verif/prs_readout_checker.sv
// assertions on the ports of the pressure readout block
// assumes it is bound to prs_readout, one core clock domain
`timescale 1ns/10ps

module prs_readout_checker
  import prs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_data,
  input wire logic rd_pressure_low,
  input wire logic result_ready_line,
  input wire prs_status_t status,
  input wire logic [15:0] temperature_result,
  input wire logic [7:0] pressure_result_high
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ready indication, command answers and result layout
  a_ready_pair: assert property (
    result_ready_line == status.result_ready) else $error("ready differs");
  a_ready_fall: assert property (
    $fell(result_ready_line) |-> $past(rd_pressure_low))
    else $error("ready fell without read");
  a_ready_hold: assert property (
    result_ready_line && !rd_pressure_low |=> result_ready_line)
    else $error("ready dropped early");
  a_busy_start: assert property (
    cmd_wr && cmd_data inside {8'h09, 8'h0a, 8'h0b, 8'h0c} &&
    !status.operation_busy_flag |=> status.operation_busy_flag)
    else $error("mode not started");
  a_cancel_busy: assert property (
    cmd_wr && cmd_data == 8'h00 && status.operation_busy_flag
    |=> status.operation_busy_flag) else $error("stop not entered");
  a_temp_unused: assert property (
    temperature_result[15:14] == 2'b00) else $error("temp top bits set");
  a_press_word: assert property (
    pressure_result_high[7:3] == 5'h00) else $error("high part too wide");
  a_ovr_set: assert property (
    $rose(status.overrun_error_flag) |-> $past(result_ready_line) &&
    !$past(rd_pressure_low)) else $error("overrun without unread result");
  a_ovr_clear: assert property (
    rd_pressure_low |=> !status.overrun_error_flag)
    else $error("overrun kept after read");
endmodule // prs_readout_checker

bind prs_readout prs_readout_checker i_prs_readout_checker (.core_clk,
  .rstn, .cmd_wr, .cmd_data, .rd_pressure_low, .result_ready_line,
  .status, .temperature_result, .pressure_result_high);

// ===== verif/prs_host.sv
// host model: command writes, pressure reads and trigger pulses
// assumes the device samples every strobe on the rising core clock
`timescale 1ns/10ps

module prs_host (
  input wire logic core_clk,
  output logic trig_pin,
  output logic cmd_wr,
  output logic [7:0] cmd_data,
  output logic rd_pressure_low
);
  // strobes and trigger idle low from time zero, before reset is released
  initial begin
    trig_pin <= 1'b0;
    cmd_wr <= 1'b0;
    cmd_data <= 8'h00;
    rd_pressure_low <= 1'b0;
  end

  // one-cycle write; caller has seen ready low, and busy low except for a cancel
  task automatic cmd(input logic [7:0] code);
    @(posedge core_clk);
    cmd_wr <= 1'b1;
    cmd_data <= code;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    cmd_data <= ~code; // bus no longer shows the taken code
  endtask

  // low-part read, last of the readout; only periodic reads needed
  task automatic rd_low();
    @(posedge core_clk);
    rd_pressure_low <= 1'b1;
    @(posedge core_clk);
    rd_pressure_low <= 1'b0;
  endtask

  // trigger pulse held two cycles; caller has read the last result
  task automatic trig();
    @(posedge core_clk);
    trig_pin <= 1'b1;
    repeat (2) @(posedge core_clk);
    trig_pin <= 1'b0;
  endtask
endmodule // prs_host

// ===== verif/tb_prs_readout.sv
// testbench of the pressure readout block, shortened timing parameters
// assumes the host model drives all strobes and the trigger pin
`timescale 1ns/10ps

module tb_prs_readout
  import prs_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic trig_pin, cmd_wr, rd_pressure_low, result_ready_line;
  logic [7:0] cmd_data, pressure_result_high;
  logic [15:0] temperature_result, pressure_result_low;
  prs_sample_t smp;
  prs_status_t status;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] codes [4] = '{8'h0a, 8'h09, 8'h0b, 8'h0c};
  int per [4] = '{20, 10, 30, 15};

  prs_readout #(.HIRES_CYC(32'd20), .HISPEED_CYC(32'd10),
    .ULP_CYC(32'd30), .TRIG_CYC(32'd15), .STOP_CYC(32'd5)) i_prs_readout (
    .core_clk, .rstn, .trig_pin, .cmd_wr, .cmd_data, .rd_pressure_low,
    .conv_sample(smp), .result_ready_line, .status, .temperature_result,
    .pressure_result_high, .pressure_result_low);
  prs_host i_prs_host (.core_clk, .trig_pin, .cmd_wr, .cmd_data,
    .rd_pressure_low);

  // 125 MHz clock
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // compare and count
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // cycles until status bit b reaches lvl, bounded
  task automatic wait_st(input int b, input logic lvl, output int c);
    c = 0;
    #1;
    while (status[b] !== lvl) begin
      @(posedge core_clk);
      #1;
      c++;
      if (c > 200) begin
        n_fail++;
        end_sim();
      end
    end
  endtask

  task automatic end_sim();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // main sequence: every mode code, trigger pin, overrun
  initial begin
    smp <= '0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({status, temperature_result}, 19'h0);
    foreach (codes[i]) begin
      smp <= {19'h5a5a5 ^ 19'(i), 14'h3f94 ^ 14'(i)};
      i_prs_host.cmd(codes[i]);
      wait_st(0, 1'b1, n);
      chk(19'(n >= per[i] - 1 && n <= per[i] + 2), 19'd1);
      chk(19'(temperature_result), {5'h00, smp.temperature});
      chk(19'(pressure_result_high), {16'h0, smp.pressure[18:16]});
      chk(19'(pressure_result_low), {3'h0, smp.pressure[15:0]});
      chk(19'(result_ready_line), 19'd1);
      i_prs_host.rd_low();
      @(posedge core_clk);
      #1;
      chk(19'(status.result_ready), 19'd0);
      i_prs_host.cmd(8'h00);
      wait_st(1, 1'b0, n);
      chk(19'(n >= 4 && n <= 6), 19'd1);
      $display("mode %h done", codes[i]);
    end
    i_prs_host.trig();
    wait_st(0, 1'b1, n);
    chk(19'(n >= 14 && n <= 19), 19'd1);
    i_prs_host.rd_low();
    // triggered mode must be cancelled before continuous mode is chosen
    i_prs_host.cmd(8'h00);
    wait_st(1, 1'b0, n);
    chk(19'(n >= 4 && n <= 6), 19'd1);
    $display("trigger pin done");
    i_prs_host.cmd(8'h0a);
    wait_st(2, 1'b1, n);
    chk(19'(n >= 38 && n <= 43), 19'd1);
    i_prs_host.rd_low();
    @(posedge core_clk);
    #1;
    chk(19'(status), 19'h2);
    i_prs_host.cmd(8'h00);
    wait_st(1, 1'b0, n);
    $display("overrun done");
    end_sim();
  end
endmodule // tb_prs_readout
